// ===== core/vft_display_scan_driver.sv
// VFT scan driver: display buffer, two control registers, status, slot timer.
// Assumes classic Wishbone single-cycle masters and a low-power level from the clock unit.
`default_nettype none

module vft_display_scan_driver #(
  // Cycles of the shortest slot, 2^10 clock periods; shorten for simulation
  parameter int SLOT_BASE_CYCLES = 2 ** vft_scan_pkg::SLOT_BASE_EXP
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Power mode
  input wire logic lowPower,
  // Pins
  input wire logic [vft_scan_pkg::NUM_LINES-1:0] portLatch,
  output logic [vft_scan_pkg::NUM_LINES-1:0] pinOut,
  output logic [vft_scan_pkg::NUM_LINES-1:0] displayMode
);
  import vft_scan_pkg::*;

  // ****************************************
  // Registers and bus decode
  // ****************************************
  logic [7:0] bufMem_q [BUF_BYTES];
  logic [LSEL_W-1:0] lineSel_q;
  logic [TSEL_W-1:0] timeSel_q;
  logic slotClkSel_q;
  logic blank_q;
  logic [DIM_W-1:0] dim_q;
  logic [STATES_W-1:0] stateCount_q;
  logic ack_q;
  logic [31:0] rdData_q;
  logic [13:0] wordIdx;
  logic req;
  logic wrStb;
  logic inBuf;
  logic [6:0] bufIdx;
  scan_state_e state_q;
  slot_t slot_q;
  cycles_t cyc_q;
  cycles_t slotLen;
  cycles_t litLen;
  logic slotEnd;
  logic lit;
  logic [NUM_LINES-1:0] scanBits;
  logic [NUM_LINES-1:0] lineMask;
  logic [NUM_LINES-1:0] pin_q;
  logic [NUM_LINES-1:0] mode_q;

  assign wordIdx = adr_i[15:2];
  assign req = cyc_i & stb_i & ~ack_q;
  assign wrStb = req & we_i & sel_i[0];
  assign inBuf = (wordIdx >= BUF_FIRST_IDX) && (wordIdx <= BUF_LAST_IDX);
  assign bufIdx = 7'(wordIdx - BUF_FIRST_IDX);

  // One answer, registered a cycle after the request; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= 32'h0000_0000;
    end else if (req && !we_i) begin
      rdData_q <= 32'h0000_0000;
      if (inBuf) begin
        rdData_q[7:0] <= bufMem_q[bufIdx];
      end else if (wordIdx == CTRL_TWO_IDX) begin
        rdData_q[DIM_LSB +: DIM_W] <= dim_q;
        rdData_q[STATES_LSB +: STATES_W] <= stateCount_q;
      end else if (wordIdx == STATE_IDX) begin
        rdData_q[ST_BLANK_BIT] <= blank_q;
        rdData_q[ST_LOWPWR_BIT] <= lowPower;
        rdData_q[ST_LIT_BIT] <= (state_q == ScanRun) & lit;
        rdData_q[ST_SLOT_LSB +: $bits(slot_t)] <= slot_q;
      end
      // Control one is not readable and answers zero
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdData_q;

  // Buffer bytes; the last column's top bits are stored as written
  always_ff @(posedge clk) begin
    if (wrStb && inBuf) begin
      bufMem_q[bufIdx] <= dat_i[7:0];
    end
  end

  // Control one: any write with sel_i[0] set loads every field except blanking, which stays set while lowPower is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineSel_q <= LSEL_RST;
      timeSel_q <= TSEL_RST;
      slotClkSel_q <= 1'b0;
    end else if (wrStb && wordIdx == CTRL_ONE_IDX) begin
      lineSel_q <= dat_i[LSEL_LSB +: LSEL_W];
      timeSel_q <= dat_i[TSEL_LSB +: TSEL_W];
      slotClkSel_q <= dat_i[CLKSEL_BIT];
    end
  end

  // Low power sets blanking and wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_q <= 1'b1;
    end else if (lowPower) begin
      blank_q <= 1'b1;
    end else if (wrStb && wordIdx == CTRL_ONE_IDX) begin
      blank_q <= dat_i[BLANK_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dim_q <= DIM_RST;
      stateCount_q <= STATES_RST;
    end else if (wrStb && wordIdx == CTRL_TWO_IDX) begin
      dim_q <= dat_i[DIM_LSB +: DIM_W];
      stateCount_q <= dat_i[STATES_LSB +: STATES_W];
    end
  end

  // ****************************************
  // Slot timing and dimmer
  // ****************************************
  // Both clock-select settings give the same slot lengths here
  assign slotLen = cycles_t'(SLOT_BASE_CYCLES) << timeSel_q;
  assign litLen = cycles_t'((slotLen >> DIM_SHIFT) * (32'(dim_q) + 32'd1));
  // At or past the end, so a shorter slot set mid-scan cannot strand the counter
  assign slotEnd = (cyc_q >= slotLen - cycles_t'(1));
  assign lit = (cyc_q < litLen);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ScanIdle;
    end else begin
      unique case (state_q)
        ScanIdle: begin
          if (!blank_q) begin
            state_q <= ScanRun;
          end
        end
        ScanRun: begin
          if (blank_q) begin
            state_q <= ScanIdle;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= '0;
      cyc_q <= '0;
    end else if (state_q != ScanRun) begin
      slot_q <= '0;
      cyc_q <= '0;
    end else if (slotEnd) begin
      cyc_q <= '0;
      slot_q <= (slot_q >= stateCount_q) ? slot_t'(0) : slot_q + slot_t'(1);
    end else begin
      cyc_q <= cyc_q + cycles_t'(1);
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    // Column per group of eight lines, byte within column per slot
    assign scanBits[i] = bufMem_q[COL_BYTES * (i / LINES_PER_COL) + int'(slot_q)][i % LINES_PER_COL];
    assign lineMask[i] = lineSel_q[i / LINES_PER_COL];
  end

  // Blanked display lines fall back to zero; other lines follow their port latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= '0;
      mode_q <= '0;
    end else begin
      mode_q <= lineMask & {NUM_LINES{state_q == ScanRun}};
      for (int i = 0; i < NUM_LINES; i++) begin
        if (lineMask[i]) begin
          pin_q[i] <= (state_q == ScanRun) & lit & scanBits[i];
        end else begin
          pin_q[i] <= portLatch[i];
        end
      end
    end
  end

  assign pinOut = pin_q;
  assign displayMode = mode_q;

  // ****************************************
  // Checks
  // ****************************************
  low_power_blank_a: assert property (@(posedge clk) disable iff (!rst_n)
    lowPower |=> blank_q ##1 state_q == ScanIdle)
    else $error("low power did not blank the scan");

  blank_pins_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ScanIdle) |=> ((pin_q & $past(lineMask)) == '0))
    else $error("display pin lit while blanked");

  start_scan_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ScanIdle && !blank_q) |=> (state_q == ScanRun && slot_q == '0 && cyc_q == '0))
    else $error("scan did not start from T0");

  slot_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ScanRun && !blank_q && slotEnd && slot_q < stateCount_q) |=> slot_q == $past(slot_q) + slot_t'(1))
    else $error("slot did not advance");

  slot_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ScanRun && !blank_q && slotEnd && slot_q >= stateCount_q) |=> slot_q == '0)
    else $error("slot did not wrap to T0");

  dim_dark_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ScanRun && !lit) |=> ((pin_q & $past(lineMask)) == '0))
    else $error("pin lit outside dimmer window");

  port_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && !lineMask[0]) |=> pin_q[0] == $past(portLatch[0]))
    else $error("general port line not passed through");

  ctrl_one_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req && !we_i && wordIdx == CTRL_ONE_IDX) |=> ack_o && dat_o == 32'h0000_0000)
    else $error("control one read back nonzero");

  buf_update_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wrStb && inBuf) |=> bufMem_q[$past(bufIdx)] == $past(dat_i[7:0]))
    else $error("buffer byte not stored");

  ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    ack_q |=> !ack_q)
    else $error("ack held more than one cycle");

  ack_follows_req_a: assert property (@(posedge clk) disable iff (!rst_n)
    req |=> ack_o)
    else $error("request not acknowledged next cycle");

  ack_only_req_a: assert property (@(posedge clk) disable iff (!rst_n)
    !req |=> !ack_o)
    else $error("ack without a taken request");

  read_ctrl_two_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req && !we_i && wordIdx == CTRL_TWO_IDX) |=>
      (dat_o[DIM_LSB +: DIM_W] == $past(dim_q) && dat_o[STATES_LSB +: STATES_W] == $past(stateCount_q)))
    else $error("control two read back wrong");

  read_buf_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req && !we_i && inBuf) |=> (dat_o[31:8] == 24'h00_0000 && dat_o[7:0] == $past(bufMem_q[bufIdx])))
    else $error("buffer byte read back wrong");

  read_unmapped_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req && !we_i && !inBuf && wordIdx != CTRL_TWO_IDX && wordIdx != STATE_IDX) |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  status_fields_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req && !we_i && wordIdx == STATE_IDX) |=>
      (dat_o[ST_BLANK_BIT] == $past(blank_q) && dat_o[ST_LOWPWR_BIT] == $past(lowPower)
       && dat_o[ST_SLOT_LSB +: $bits(slot_t)] == $past(slot_q)))
    else $error("status fields read back wrong");

  status_lit_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req && !we_i && wordIdx == STATE_IDX) |=> dat_o[ST_LIT_BIT] == $past(state_q == ScanRun && lit))
    else $error("status lit bit wrong");

  read_data_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req && we_i) |=> dat_o == $past(dat_o))
    else $error("read data changed on a write");

  ctrl_one_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wrStb && wordIdx == CTRL_ONE_IDX) |=>
      (lineSel_q == $past(dat_i[LSEL_LSB +: LSEL_W]) && timeSel_q == $past(dat_i[TSEL_LSB +: TSEL_W])))
    else $error("control one fields not stored");

  ctrl_one_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(wrStb && wordIdx == CTRL_ONE_IDX) |=> (lineSel_q == $past(lineSel_q) && timeSel_q == $past(timeSel_q)))
    else $error("control one changed without a write");

  blank_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wrStb && wordIdx == CTRL_ONE_IDX && !lowPower) |=> blank_q == $past(dat_i[BLANK_BIT]))
    else $error("blanking bit not stored");

  blank_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!lowPower && !(wrStb && wordIdx == CTRL_ONE_IDX)) |=> blank_q == $past(blank_q))
    else $error("blanking bit changed on its own");

  ctrl_two_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wrStb && wordIdx == CTRL_TWO_IDX) |=>
      (dim_q == $past(dat_i[DIM_LSB +: DIM_W]) && stateCount_q == $past(dat_i[STATES_LSB +: STATES_W])))
    else $error("control two fields not stored");

  ctrl_two_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(wrStb && wordIdx == CTRL_TWO_IDX) |=> (dim_q == $past(dim_q) && stateCount_q == $past(stateCount_q)))
    else $error("control two changed without a write");

  stop_scan_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ScanRun && blank_q) |=> state_q == ScanIdle)
    else $error("scan kept running while blanked");

  idle_counter_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ScanIdle) |=> (slot_q == '0 && cyc_q == '0))
    else $error("slot counters not cleared while idle");

  cycle_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ScanRun && !slotEnd) |=> (cyc_q == $past(cyc_q) + cycles_t'(1) && slot_q == $past(slot_q)))
    else $error("slot time did not count");

  slot_end_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ScanRun && slotEnd) |=> cyc_q == '0)
    else $error("slot time not restarted");

  lit_window_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ScanRun && lit && lineMask[0]) |=> pin_q[0] == $past(scanBits[0]))
    else $error("lit line does not follow its buffer bit");

  first_eighth_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ScanRun && cyc_q < (slotLen >> DIM_SHIFT)) |-> lit)
    else $error("first eighth of slot not lit");

  mode_run_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ScanRun) |=> displayMode == $past(lineMask))
    else $error("display use flags wrong while scanning");

  mode_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ScanIdle) |=> displayMode == '0)
    else $error("display use flagged while blanked");

  port_high_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && !lineMask[NUM_LINES-1]) |=> pin_q[NUM_LINES-1] == $past(portLatch[NUM_LINES-1]))
    else $error("top general port line not passed through");

endmodule

`default_nettype wire

// ===== core/vft_scan_pkg.sv
// Constants, register map and field layout for the display scan driver.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave port.
//
// How it works
// - Thirty-seven output lines, 0 to 36, driven from the scan while in display use.
// - Software picks 1 to 16 time slots, T0 to T15.
// - Five-bit line select field hands each pin group to display or general port.
// - Buffer bytes reach the pins automatically; writing the buffer changes the pattern.
// - Dimmer shortens the lit part of each slot in eight steps.
// - Control one holds slot duration (powers of two of clock) and line selection.
// - Control two holds dimmer level and number of scan states.
// - Low-power entry blanks, drives display pins to 0, leaves them general outputs.
// - Control one is write-only and must be written whole.
// - Clearing the blanking bit starts the scan.
// - Buffer spans locations 00F80 to 00FCF and is display-only.
// - Each buffer bit drives one line, except bits 5 to 7 of the last column, which drive none; a 1 lights it during its slot.
// - Five 16-byte columns map to line groups; low nibble selects the slot.
// - A status register reports the driver's current state.
// - Segment and grid roles follow buffer contents only, never fixed pins.
`default_nettype none

package vft_scan_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int NUM_LINES = 37;
  localparam int NUM_COLS = 5;
  localparam int NUM_SLOTS = 16;
  localparam int COL_BYTES = 16;
  localparam int BUF_BYTES = NUM_COLS * COL_BYTES;
  localparam int LINES_PER_COL = 8;

  typedef logic [3:0] slot_t;
  typedef logic [15:0] cycles_t;

  // ****************************************
  // Register map (word indices, byte address = 4 * index)
  // ****************************************
  localparam logic [13:0] BUF_FIRST_IDX = 14'h0F80;
  localparam logic [13:0] BUF_LAST_IDX = 14'h0FCF;
  localparam logic [13:0] CTRL_ONE_IDX = 14'h0010;
  localparam logic [13:0] CTRL_TWO_IDX = 14'h0011;
  localparam logic [13:0] STATE_IDX = 14'h0012;

  // ****************************************
  // Fields
  // ****************************************
  localparam int LSEL_LSB = 0;
  localparam int LSEL_W = 5;
  localparam int TSEL_LSB = 5;
  localparam int TSEL_W = 2;
  localparam int CLKSEL_BIT = 7;
  localparam int BLANK_BIT = 8;
  localparam int DIM_LSB = 0;
  localparam int DIM_W = 3;
  localparam int STATES_LSB = 4;
  localparam int STATES_W = 4;
  localparam int ST_BLANK_BIT = 0;
  localparam int ST_LOWPWR_BIT = 1;
  localparam int ST_LIT_BIT = 2;
  localparam int ST_SLOT_LSB = 4;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [LSEL_W-1:0] LSEL_RST = 5'h00;
  localparam logic [TSEL_W-1:0] TSEL_RST = 2'h0;
  localparam logic [DIM_W-1:0] DIM_RST = 3'h7;
  localparam logic [STATES_W-1:0] STATES_RST = 4'hF;
  localparam int SLOT_BASE_EXP = 10;
  localparam int DIM_SHIFT = 3;

  typedef enum logic {ScanIdle, ScanRun} scan_state_e;

endpackage

`default_nettype wire

// ===== verification/vft_display_scan_driver_bench.sv
// Bench for the display scan driver: registers, scan order, dimmer, low power.
// Assumes a 16-cycle base slot and the tube model beside the pins.
`default_nettype none

module vft_display_scan_driver_bench import vft_scan_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic lowPower = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] datOut;
  logic [31:0] rd;
  logic ack;
  logic [NUM_LINES-1:0] portLatch = 37'h15_5555_5555;
  logic [NUM_LINES-1:0] pinOut;
  logic [NUM_LINES-1:0] displayMode;
  logic [15:0] runLen;
  int failCount = 0;
  int nChecks = 0;

  vft_display_scan_driver #(.SLOT_BASE_CYCLES(16)) u_dut (
    .clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hF), .dat_i(dat), .dat_o(datOut), .ack_o(ack), .lowPower(lowPower),
    .portLatch(portLatch), .pinOut(pinOut), .displayMode(displayMode));
  vft_tube_model u_tube (.clk(clk), .rst_n(rst_n), .pinOut(pinOut), .displayMode(displayMode), .runLen(runLen));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test();
    if (failCount == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle; request held until ack is seen
  task automatic bus(input logic w, input logic [13:0] i, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) begin
      failCount++;
      finish_test();
    end
    q = datOut;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic waitPin(input int b, input logic v);
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge clk);
      if (pinOut[b] === v) break;
    end
    if (pinOut[b] !== v) begin
      failCount++;
      finish_test();
    end
  endtask

  initial begin
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, CTRL_TWO_IDX, 32'h0000_0000, rd);
    chk(rd, 32'h0000_00F7);
    bus(1'b0, STATE_IDX, 32'h0000_0000, rd);
    chk(rd & 32'h0000_000F, 32'h0000_0001);
    bus(1'b0, CTRL_ONE_IDX, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    bus(1'b0, 14'h0100, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    chk(pinOut[31:0], portLatch[31:0]);
    bus(1'b1, BUF_FIRST_IDX, 32'h0000_0001, rd);
    bus(1'b1, BUF_FIRST_IDX + 14'h0001, 32'h0000_0002, rd);
    bus(1'b1, BUF_FIRST_IDX + 14'h0040, 32'h0000_0010, rd);
    bus(1'b1, BUF_FIRST_IDX + 14'h0041, 32'h0000_0000, rd);
    bus(1'b0, BUF_FIRST_IDX + 14'h0040, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0010);
    // Columns 0 and 4 in display use, two slots, full brightness
    bus(1'b1, CTRL_ONE_IDX, 32'h0000_0111, rd);
    bus(1'b1, CTRL_TWO_IDX, 32'h0000_0017, rd);
    bus(1'b1, CTRL_ONE_IDX, 32'h0000_0011, rd);
    waitPin(0, 1'b1);
    chk(32'(pinOut[36]), 32'h0000_0001);
    chk(32'(pinOut[8]), 32'(portLatch[8]));
    chk(32'(displayMode[0]), 32'h0000_0001);
    waitPin(1, 1'b1);
    chk(32'(pinOut[0]), 32'h0000_0000);
    chk(32'(pinOut[36]), 32'h0000_0000);
    waitPin(0, 1'b1);
    chk(32'(runLen), 32'h0000_0010);
    bus(1'b0, STATE_IDX, 32'h0000_0000, rd);
    chk(rd & 32'h0000_00F7, 32'h0000_0004);
    // Longer slot, dimmest level: an eighth of 32 cycles
    bus(1'b1, CTRL_ONE_IDX, 32'h0000_0111, rd);
    bus(1'b1, CTRL_TWO_IDX, 32'h0000_0010, rd);
    bus(1'b1, CTRL_ONE_IDX, 32'h0000_0031, rd);
    waitPin(1, 1'b1);
    chk(32'(runLen), 32'h0000_0004);
    bus(1'b0, STATE_IDX, 32'h0000_0000, rd);
    chk(rd & 32'h0000_00F3, 32'h0000_0010);
    // Longest slot, half brightness: 64 of 128 cycles lit
    bus(1'b1, CTRL_ONE_IDX, 32'h0000_0111, rd);
    bus(1'b1, CTRL_TWO_IDX, 32'h0000_0013, rd);
    bus(1'b1, CTRL_ONE_IDX, 32'h0000_0071, rd);
    waitPin(1, 1'b1);
    chk(32'(runLen), 32'h0000_0040);
    lowPower <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(pinOut[36:32]), 32'h0000_0000);
    chk(displayMode[31:0], 32'h0000_0000);
    bus(1'b0, STATE_IDX, 32'h0000_0000, rd);
    chk(rd & 32'h0000_0007, 32'h0000_0003);
    lowPower <= 1'b0;
    finish_test();
  end
endmodule

`default_nettype wire

// ===== verification/vft_tube_model.sv
// Tube model: watches the display lines and measures how long line 0 stays lit.
// Assumes registered pin outputs from the scan driver on the same clock.
`default_nettype none

module vft_tube_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Tube side
  input wire logic [36:0] pinOut,
  input wire logic [36:0] displayMode,
  // Observation
  output logic [15:0] runLen
);
  logic [15:0] cnt_q;

  // ****************************************
  // Lit run length of line 0
  // ****************************************
  // A segment glows only while driven high in display use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      runLen <= 16'h0000;
    end else if (pinOut[0] && displayMode[0]) begin
      cnt_q <= cnt_q + 16'h0001;
    end else begin
      if (cnt_q != 16'h0000) begin
        runLen <= cnt_q;
      end
      cnt_q <= 16'h0000;
    end
  end
endmodule

`default_nettype wire
